// >>> port_analog_function_select.sv
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module port_analog_function_select
    import port_analog_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1      // 1 = larger package, 0 = 64-pin
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire reg_req_type   regReq,      // Register request bundle
    output logic        [15:0] rdData,      // Read data, cycle after rd
    input  wire port_word_type pinIn,       // Raw pin levels, ports A to D
    output port_word_type      analogMode,  // 1 = pin in analog mode
    output port_word_type      portRead     // Digital read path per pin
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic        selHit;        // Address falls on a selection register
    logic        dataHit;       // Address falls on a port data register
    logic [1:0]  portIdx;       // Port addressed
    logic [15:0] rdData_next;   // Read value before the output flop
    logic [15:0] rdData_reg;    // Registered read data

    port_word_type selValue;    // Selection registers
    port_word_type pinLevel;    // Synchronised pin levels
    port_word_type portRead_reg;// Digital read path, gated

    assign portIdx = regReq.addr[1:0];
    assign selHit  = (regReq.addr >= ADDR_PORTA_SEL) && (regReq.addr < ADDR_PORTA_DATA);
    assign dataHit = (regReq.addr >= ADDR_PORTA_DATA) && (regReq.addr <= ADDR_PORTD_DATA);

    // ----------------------------------------
    // Per-port selection register and pin sync
    // ----------------------------------------
    // The small package drops port A entirely and port C bit 4; the mask
    // is fixed at elaboration so absent bits cost no selector flops; every pin still gets a full-width synchroniser
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        localparam logic [15:0] LARGE_M =
            (g == 0) ? PORTA_MASK :
            (g == 1) ? PORTB_MASK :
            (g == 2) ? PORTC_MASK_LARGE :
                       PORTD_MASK;
        localparam logic [15:0] SMALL_M =
            (g == 0) ? ABSENT_MASK :
            (g == 2) ? PORTC_MASK_SMALL :
                       LARGE_M;
        localparam logic [15:0] M = LARGE_PACKAGE ? LARGE_M : SMALL_M;

        // Write enable for this port only
        logic wrEn;
        assign wrEn = regReq.wr && selHit && (portIdx == 2'(g));

        analog_select_reg #(
            .MASK   (M)
        ) u_sel (
            .mclk   (mclk),
            .rst_n  (rst_n),
            .wrEn   (wrEn),
            .wrData (regReq.wdata),
            .value  (selValue[g])
        );

        pin_input_sync #(
            .WIDTH  (PORT_WIDTH)
        ) u_sync (
            .mclk   (mclk),
            .rst_n  (rst_n),
            .pinIn  (pinIn[g]),
            .level  (pinLevel[g])
        );
    end

    // ----------------------------------------
    // Digital read path
    // ----------------------------------------
    // An analog pin reads low; a digital pin passes its level.
    // Masking also keeps a floating analog pad off the read path; its synchroniser still samples it.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            portRead_reg <= '0;
        end else begin
            portRead_reg <= pinLevel & ~selValue;
        end
    end

    assign portRead   = portRead_reg;
    assign analogMode = selValue;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // Unmapped addresses answer zero
    always_comb begin
        rdData_next = ZERO_WORD;
        if (selHit) begin
            rdData_next = selValue[portIdx];
        end else if (dataHit) begin
            rdData_next = portRead_reg[portIdx];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_reg <= ZERO_WORD;
        end else if (regReq.rd) begin
            rdData_reg <= rdData_next;
        end else begin
            rdData_reg <= ZERO_WORD;
        end
    end

    assign rdData = rdData_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_rd_porta_sel;
        regReq.rd && regReq.addr == ADDR_PORTA_SEL;
    endsequence

    sequence s_wr_then_rd_portb;
        (regReq.wr && regReq.addr == ADDR_PORTB_SEL) ##1
        (regReq.rd && regReq.addr == ADDR_PORTB_SEL);
    endsequence

    a_porta_mask: assert property (@(posedge mclk) disable iff (!rst_n)
        s_rd_porta_sel |=> (rdData & ~PORTA_MASK) == 16'h0000)
        else $error("Port A read shows bits outside its selectors");

    a_porta_absent: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_rd_porta_sel and !LARGE_PACKAGE) |=> rdData == 16'h0000)
        else $error("Port A register present on small package");

    a_portb_full: assert property (@(posedge mclk) disable iff (!rst_n)
        s_wr_then_rd_portb |=> rdData == $past(regReq.wdata, 2))
        else $error("Port B read-back differs from written word");

    a_portc_mask: assert property (@(posedge mclk) disable iff (!rst_n)
        regReq.rd && regReq.addr == ADDR_PORTC_SEL
        |=> (rdData & ~PORTC_MASK_LARGE) == 16'h0000)
        else $error("Port C read shows unimplemented bits");

    a_portc_pin4: assert property (@(posedge mclk) disable iff (!rst_n)
        !LARGE_PACKAGE && regReq.rd && regReq.addr == ADDR_PORTC_SEL
        |=> rdData[4] == 1'b0)
        else $error("Port C bit 4 present on small package");

    a_portd_mask: assert property (@(posedge mclk) disable iff (!rst_n)
        regReq.rd && regReq.addr == ADDR_PORTD_SEL
        |=> (rdData & ~PORTD_MASK) == 16'h0000)
        else $error("Port D read shows unimplemented bits");

    a_analog_low: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 (portRead_reg & $past(selValue)) == '0)
        else $error("Analog pin leaked onto the digital read path");

    a_digital_pass: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 portRead_reg == ($past(pinLevel) & ~$past(selValue)))
        else $error("Digital pin level not passed to read path");

    a_data_read: assert property (@(posedge mclk) disable iff (!rst_n)
        regReq.rd && dataHit
        |=> rdData == $past(portRead_reg[portIdx]))
        else $error("Port data read returned wrong word");

    a_idle_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        !regReq.rd |=> rdData == 16'h0000)
        else $error("Read data stood outside its cycle");

endmodule // port_analog_function_select
`default_nettype wire

// >>> port_analog_pkg.sv
package port_analog_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NUM_PORTS  = 4;          // Ports A to D
    localparam int PORT_WIDTH = 16;         // Pins per port
    localparam int ADDR_WIDTH = 4;          // Register address width

    // ----------------------------------------
    // Register map (word indices)
    // ----------------------------------------
    localparam logic [3:0] ADDR_PORTA_SEL  = 4'h0;
    localparam logic [3:0] ADDR_PORTB_SEL  = 4'h1;
    localparam logic [3:0] ADDR_PORTC_SEL  = 4'h2;
    localparam logic [3:0] ADDR_PORTD_SEL  = 4'h3;
    localparam logic [3:0] ADDR_PORTA_DATA = 4'h4;
    localparam logic [3:0] ADDR_PORTD_DATA = 4'h7;

    // ----------------------------------------
    // Implemented selector masks, also reset values
    // ----------------------------------------
    localparam logic [15:0] PORTA_MASK       = 16'h06C0;
    localparam logic [15:0] PORTB_MASK       = 16'hFFFF;
    localparam logic [15:0] PORTC_MASK_LARGE = 16'h6010;
    localparam logic [15:0] PORTC_MASK_SMALL = 16'h6000;
    localparam logic [15:0] PORTD_MASK       = 16'h00C0;
    localparam logic [15:0] ABSENT_MASK      = 16'h0000;
    localparam logic [15:0] ZERO_WORD        = 16'h0000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] port_word_type;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;    // Register index
        logic [15:0]           wdata;   // Write data
        logic                  wr;      // Write strobe
        logic                  rd;      // Read strobe
    } reg_req_type;

endpackage

// >>> pin_input_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_input_sync
    import port_analog_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] level
);

    // ----------------------------------------
    // Three-stage synchroniser
    // ----------------------------------------
    logic [WIDTH-1:0] stage1_reg;   // Metastable stage, read only by stage2
    logic [WIDTH-1:0] stage2_reg;   // First settled copy
    logic [WIDTH-1:0] stage3_reg;   // Second settled copy
    logic [WIDTH-1:0] level_reg;    // Accepted pin level

    // Shift the pins through the chain
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A change is accepted only once stages two and three agree,
    // which rejects a one-cycle glitch at the cost of latency
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= '0;
        end else begin
            level_reg <= (stage2_reg & stage3_reg) | (level_reg & (stage2_reg ^ stage3_reg));
        end
    end

    assign level = level_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_sync_agree: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(level_reg) |->
            ((level_reg ^ $past(level_reg)) & $past(stage2_reg ^ stage3_reg)) == '0)
        else $error("Pin level changed while sync stages disagreed");

endmodule // pin_input_sync
`default_nettype wire

// >>> analog_select_reg.sv
`timescale 1ns/100ps
`default_nettype none
module analog_select_reg
    import port_analog_pkg::*;
#(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        wrEn,
    input  wire logic [15:0] wrData,
    output logic      [15:0] value
);

    // ----------------------------------------
    // Selection storage
    // ----------------------------------------
    logic [15:0] value_reg;     // Selector bits, zero where unimplemented

    // Reset sets every implemented selector, so pins start analog
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= MASK;
        end else if (wrEn) begin
            value_reg <= wrData & MASK;
        end
    end

    assign value = value_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_write_update: assert property (@(posedge mclk) disable iff (!rst_n)
        wrEn |=> value_reg == ($past(wrData) & MASK))
        else $error("Selector write did not store masked data");

    a_hold_value: assert property (@(posedge mclk) disable iff (!rst_n)
        !wrEn |=> $stable(value_reg))
        else $error("Selector changed without a write");

    a_unimpl_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (value_reg & ~MASK) == 16'h0000)
        else $error("Unimplemented selector bit is set");

endmodule // analog_select_reg
`default_nettype wire

// >>> tb_port_analog_function_select.sv
`timescale 1ns/100ps
`default_nettype none
module tb_port_analog_function_select
    import port_analog_pkg::*;
;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic          mclk;          // System clock, 20 ns
    logic          rst_n;         // Active-low reset
    reg_req_type   regReq;        // Register request bundle
    port_word_type pinIn;         // Pin levels shared by both variants
    logic   [15:0] rdL;           // Read data, larger package
    logic   [15:0] rdS;           // Read data, 64-pin package
    port_word_type modeL;         // Analog mode, larger package
    port_word_type modeS;         // Analog mode, 64-pin package
    port_word_type readL;         // Digital read, larger package
    port_word_type readS;         // Digital read, 64-pin package
    logic   [15:0] mskL [4];      // Implemented bits, larger package
    logic   [15:0] mskS [4];      // Implemented bits, 64-pin package
    logic   [15:0] selL [4];      // Reference selectors, larger package
    logic   [15:0] selS [4];      // Reference selectors, 64-pin package
    logic   [31:0] rnd;           // Pseudo-random state
    int            err_total;     // Mismatches
    int            total_checks;  // Comparisons made
    int            cycles = 0;    // Watchdog count, driven only by the watchdog

    // Both variants see the same traffic so differences show side by side
    port_analog_function_select #(.LARGE_PACKAGE(1'b1)) port_analog_function_select_i (
        .mclk(mclk), .rst_n(rst_n), .regReq(regReq), .rdData(rdL),
        .pinIn(pinIn), .analogMode(modeL), .portRead(readL));
    port_analog_function_select #(.LARGE_PACKAGE(1'b0)) port_analog_function_select_small_i (
        .mclk(mclk), .rst_n(rst_n), .regReq(regReq), .rdData(rdS),
        .pinIn(pinIn), .analogMode(modeS), .portRead(readS));

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Whole run needs well under 2000 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; strobes are replaced by the next call, so calls may run back to back
    task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic w, input logic r);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask

    // A run of writes must end with rdChk, which drops the strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(a, d, 1'b1, 1'b0);
        if (a < 4) begin
            selL[a[1:0]] = d & mskL[a[1:0]];
            selS[a[1:0]] = d & mskS[a[1:0]];
        end
    endtask

    task automatic rdChk(input logic [3:0] a);
        logic [15:0] eL;
        logic [15:0] eS;
        eL = 16'h0000;
        eS = 16'h0000;
        if (a < 4) begin
            eL = selL[a[1:0]];
            eS = selS[a[1:0]];
        end else if (a < 8) begin
            eL = pinIn[a[1:0]] & ~selL[a[1:0]];
            eS = pinIn[a[1:0]] & ~selS[a[1:0]];
        end
        bus(a, 16'h0000, 1'b0, 1'b1);
        @(posedge mclk);
        regReq.rd <= 1'b0;
        #1;
        chk(rdL, eL);
        if (a != 4) begin
            chk(rdS, eS);
        end
        @(posedge mclk);
        #1;
        chk(rdL | rdS, 16'h0000);
    endtask

    // Port A pins do not exist on the small part, so its digital read is not judged
    task automatic portChk();
        // Step off the edge so freshly launched outputs have settled
        #1;
        for (int p = 0; p < 4; p++) begin
            chk(modeL[p], selL[p]);
            chk(modeS[p], selS[p]);
            chk(readL[p], pinIn[p] & ~selL[p]);
            if (p > 0) begin
                chk(readS[p], pinIn[p] & ~selS[p]);
            end
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rnd = 32'h1C2D;
        err_total = 0;
        total_checks = 0;
        mskL = '{PORTA_MASK, PORTB_MASK, PORTC_MASK_LARGE, PORTD_MASK};
        mskS = '{ABSENT_MASK, PORTB_MASK, PORTC_MASK_SMALL, PORTD_MASK};
        selL = mskL;
        selS = mskS;
        rst_n = 1'b0;
        regReq = '0;
        pinIn = '1;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        // Let the pin synchronisers fill before judging data reads
        repeat (6) @(posedge mclk);
        for (int a = 0; a < 8; a++) begin
            rdChk(a[3:0]);
        end
        portChk();
        $display("test reset values done");
        // Random writes to any address, including data and unmapped places
        for (int i = 0; i < 40; i++) begin
            rnd = lfsr(rnd);
            pinIn <= {rnd, lfsr(rnd)};
            // New pin levels need five edges to reach the read path
            repeat (6) @(posedge mclk);
            rnd = lfsr(lfsr(rnd));
            wr(rnd[3:0], rnd[31:16]);
            rdChk(rnd[3:0]);
            repeat (6) @(posedge mclk);
            portChk();
            rdChk({2'b01, rnd[9:8]});
            rdChk({2'b00, rnd[9:8]});
        end
        $display("test random access done");
        // All digital, then all analog, on every selection register
        for (int v = 0; v < 2; v++) begin
            for (int a = 0; a < 4; a++) begin
                wr(a[3:0], v ? 16'hFFFF : 16'h0000);
            end
            rdChk(4'h3);
            repeat (2) @(posedge mclk);
            portChk();
            for (int a = 0; a < 8; a++) begin
                rdChk(a[3:0]);
            end
        end
        $display("test boundary patterns done");
        report_and_stop();
    end
endmodule // tb_port_analog_function_select
`default_nettype wire
